// >>> hw/fps_pkg.sv
// package for the front panel input scanner: sizes, timing, jumper layout
// assumes a single 250 MHz clock shared by both ends
package fps_pkg;
    localparam int unsigned CLK_MHZ       = 250;      // clock rate in MHz
    localparam int unsigned ROWS          = 4;        // keypad row lines
    localparam int unsigned COLS          = 8;        // keypad column lines
    localparam int unsigned ROW_W         = 2;        // row index width
    localparam int unsigned COL_W         = 3;        // column index width
    localparam int unsigned KEY_W         = 5;        // key code width
    localparam int unsigned WAKE_N        = 4 + ROWS + COLS; // watched lines
    localparam int unsigned PULSE_MS      = 20;       // wake pulse length, ms
    localparam int unsigned PULSE_CYC     = PULSE_MS * 1000 * CLK_MHZ;
    localparam int unsigned PULSE_W       = 23;       // width of pulse count
    localparam int unsigned JMP_N         = 10;       // jumper positions
    localparam int unsigned JMP_IDX_W     = 4;        // jumper index width
    localparam int unsigned PORT_W        = 8;        // processor port width
    localparam logic [KEY_W-1:0] KEY_LAST = 5'h1f;    // last scan position
    localparam logic [JMP_N-1:0] JMP_RST  = 10'h000;  // all lockouts off
    localparam logic [PULSE_W-1:0]   PULSE_LAST   = 23'h000001; // final count
    localparam logic [JMP_IDX_W-1:0] JMP_LAST_BIT = 4'h1;  // one bit left
    localparam logic [JMP_IDX_W-1:0] JMP_DONE     = 4'hf;  // read spent
    // jumper positions as the processor reads them, lsb first
    localparam int unsigned JMP_ALL_LOCK  = 0;
    localparam int unsigned JMP_FREQ_LOCK = 1;
    localparam int unsigned JMP_DISP_LOCK = 2;
    localparam int unsigned JMP_MODE_LOCK = 3;
    localparam int unsigned JMP_PWR_LOCK  = 4;
    localparam int unsigned JMP_PTT_LOCK  = 5;
    localparam int unsigned JMP_MORSE_LOCK= 6;
    localparam int unsigned JMP_XCVR_LOCK = 7;
endpackage : fps_pkg

// >>> hw/fps_if.sv
// interface joining the panel scanner and the panel processor
// assumes both ends run on the same i_mclk
`timescale 1ns/1ns
interface fps_if;
    logic                          key_valid;   // scan halted, code held
    logic [fps_pkg::KEY_W-1:0]     key_code;    // captured key code
    logic                          restart;     // toggled to resume scan
    logic                          wake_irq;    // 20 ms interrupt pulse
    logic                          supply_rst_n;// processor held in reset
    logic                          jmp_req;     // one-cycle read request
    logic                          jmp_sdat;    // serial jumper bit
    logic                          jmp_sval;    // serial bit strobe
    modport scanner (output key_valid, key_code, wake_irq, supply_rst_n,
                     jmp_sdat, jmp_sval, input restart, jmp_req);
    modport processor (input key_valid, key_code, wake_irq, supply_rst_n,
                       jmp_sdat, jmp_sval, output restart, jmp_req);
endinterface : fps_if

// >>> hw/fps_scanner.sv
// panel end: keypad scanner, wake-up pulse, supply reset, jumper serializer
// assumes panel inputs already synchronous to i_mclk
// Notes on behaviour
// RQ1: key press halts the scan oscillator
// RQ2: running counter selects row and column
// RQ3: halted count captured as unique key code
// RQ4: processor toggles restart to resume scanning
// RQ5: parity tree flags any input line change; the code misses an even number of lines changing in one cycle
// RQ6: wake change gives one 20 ms pulse
// RQ7: reset held while supply out of window
// RQ8: jumpers serialized, read once at power-up
// RQ9: processor decodes jumper positions as lockouts
// RQ10: every jumper position defaults to off
// RQ11: processor offers three 8-bit ports
// RQ12: processor core runs from its crystal
// RQ13: idle scan counter wraps and continues
`timescale 1ns/1ns
module fps_scanner (
    input  wire logic                        i_mclk,
    input  wire logic                        i_reset_n,
    fps_if.scanner                           link,
    input  wire logic [fps_pkg::ROWS-1:0]    i_key_rows,
    input  wire logic [fps_pkg::COLS-1:0]    i_key_cols,
    input  wire logic                        i_push_to_talk_input,
    input  wire logic                        i_morse_key_input,
    input  wire logic [1:0]                  i_clarifier_control,
    input  wire logic                        i_supply_ok,
    input  wire logic [fps_pkg::JMP_N-1:0]   i_jumper_fitted,
    output logic      [fps_pkg::ROW_W-1:0]   o_scan_row,
    output logic      [fps_pkg::COL_W-1:0]   o_scan_col
);
    // scan loop states, one-hot; held means a code waits for the processor
    typedef enum logic [1:0] {
        ST_SCAN = 2'h1,   // counter running
        ST_HELD = 2'h2    // stopped on a key
    } fps_state_e;

    // registers and their next values, group by group
    fps_state_e                     state_q, state_d;   // scan state
    logic [fps_pkg::KEY_W-1:0]      cnt_q, cnt_d;       // scan counter
    logic [fps_pkg::KEY_W-1:0]      code_q, code_d;     // captured code
    logic                           rst_q, rst_d;       // last restart level
    logic                           par_q, par_d;       // last parity
    logic [fps_pkg::PULSE_W-1:0]    pls_q, pls_d;       // pulse countdown
    logic                           irq_q, irq_d;       // interrupt out
    logic                           srst_q, srst_d;     // supply reset_n
    logic [fps_pkg::JMP_N-1:0]      jsh_q, jsh_d;       // jumper shifter
    logic [fps_pkg::JMP_IDX_W-1:0]  jcnt_q, jcnt_d;     // bits remaining
    logic                           jdat_q, jdat_d;     // serial bit
    logic                           jval_q, jval_d;     // serial strobe
    logic                           hit;                // selected key down
    logic                           parity;             // xor of watched lines
    logic                           vld_q, vld_d;       // key code valid

    // row part of a scan position; the row sits above the column bits
    function automatic logic [fps_pkg::ROW_W-1:0] row_of(
        input logic [fps_pkg::KEY_W-1:0] pos
    );
        row_of = pos[fps_pkg::KEY_W-1:fps_pkg::COL_W];
    endfunction : row_of

    // column part of a scan position, the low bits
    function automatic logic [fps_pkg::COL_W-1:0] col_of(
        input logic [fps_pkg::KEY_W-1:0] pos
    );
        col_of = pos[fps_pkg::COL_W-1:0];
    endfunction : col_of

    // current counter position probes one row and one column
    always_comb begin
        // two keys in different rows and columns can ghost; the first position wins
        hit = i_key_rows[row_of(cnt_q)]
            & i_key_cols[col_of(cnt_q)]; // see RQ1
        parity = ^{i_push_to_talk_input, i_morse_key_input,
                   i_clarifier_control, i_key_rows, i_key_cols}; // see RQ5
    end

    // scan loop: run, stop on hit, wait for restart toggle
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        code_d  = code_q;
        rst_d   = link.restart;
        // the counter is left alone while held, so the code stays put
        case (state_q)
            ST_SCAN: begin
                if (hit) begin
                    state_d = ST_HELD;           // see RQ1
                    code_d  = cnt_q;             // see RQ3
                end else if (cnt_q == fps_pkg::KEY_LAST) begin
                    cnt_d = '0;                  // see RQ13
                end else begin
                    cnt_d = cnt_q + 1'b1;        // see RQ2
                end
            end
            ST_HELD: begin
                // a toggle in either direction resumes, see RQ4
                if (link.restart != rst_q) begin
                    state_d = ST_SCAN;
                end
            end
            default: state_d = ST_SCAN;
        endcase
        // flop copy of the held state, so key_valid leaves a register
        vld_d = (state_d == ST_HELD);            // see RQ3
    end

    // wake-up one-shot; a change during a pulse is not retriggered
    always_comb begin
        par_d = parity;
        pls_d = pls_q;
        irq_d = irq_q;
        // parity is tracked through a pulse, so no stale edge follows it
        if (pls_q != '0) begin
            pls_d = pls_q - 1'b1;
            irq_d = (pls_q != fps_pkg::PULSE_LAST); // drop at the end
        end else if (parity != par_q) begin
            pls_d = fps_pkg::PULSE_W'(fps_pkg::PULSE_CYC); // see RQ6
            irq_d = 1'b1;
        end
    end

    // supply window and jumper serializer
    always_comb begin
        srst_d = i_supply_ok;                    // see RQ7
        jsh_d  = jsh_q;
        jcnt_d = jcnt_q;
        jdat_d = 1'b0;
        jval_d = 1'b0;
        // data and strobe stay low unless a bit is on its way
        if (!srst_q) begin
            jcnt_d = '0;                         // reread after each reset
        end else if (link.jmp_req && jcnt_q == '0) begin
            jsh_d  = i_jumper_fitted;            // see RQ8
            jcnt_d = fps_pkg::JMP_IDX_W'(fps_pkg::JMP_N);
        end else if (jcnt_q != '0 && jcnt_q != fps_pkg::JMP_DONE) begin
            jdat_d = jsh_q[0];                   // lsb first, see RQ8
            jval_d = 1'b1;
            jsh_d  = jsh_q >> 1;
            // the spent code blocks a second read until the supply drops
            jcnt_d = (jcnt_q == fps_pkg::JMP_LAST_BIT)
                   ? fps_pkg::JMP_DONE : jcnt_q - 1'b1; // once only
        end
    end

    // scan group registers; scanning starts from position zero
    // rst_q follows restart every cycle, so only a fresh toggle counts
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= ST_SCAN;
            cnt_q   <= '0;
            code_q  <= '0;
            rst_q   <= 1'b0;
            vld_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            code_q  <= code_d;
            rst_q   <= rst_d;
            vld_q   <= vld_d;
        end
    end

    // wake group registers; parity starts from the all-low idle level
    // the 23-bit count covers the full 20 ms at this clock
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            par_q   <= 1'b0;
            pls_q   <= '0;
            irq_q   <= 1'b0;
        end else begin
            par_q   <= par_d;
            pls_q   <= pls_d;
            irq_q   <= irq_d;
        end
    end

    // supply and jumper registers; shifter resets to all off, see RQ10
    // supply reset starts asserted, so the processor waits for a clean edge
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            srst_q  <= 1'b0;
            jsh_q   <= fps_pkg::JMP_RST;
            jcnt_q  <= '0;
            jdat_q  <= 1'b0;
            jval_q  <= 1'b0;
        end else begin
            srst_q  <= srst_d;
            jsh_q   <= jsh_d;
            jcnt_q  <= jcnt_d;
            jdat_q  <= jdat_d;
            jval_q  <= jval_d;
        end
    end

    // interface outputs, every one straight from a register
    assign link.key_valid    = vld_q;
    assign link.key_code     = code_q;
    assign link.wake_irq     = irq_q;
    assign link.supply_rst_n = srst_q;
    assign link.jmp_sdat     = jdat_q;
    assign link.jmp_sval     = jval_q;

    // scan position, split by the same decoders as the key probe
    assign o_scan_row = row_of(cnt_q);
    assign o_scan_col = col_of(cnt_q);
endmodule : fps_scanner

// >>> hw/fps_processor.sv
// processor end: reads keys and jumpers, drives its three ports
// assumes i_mclk stands in for the crystal-derived core clock
`timescale 1ns/1ns
module fps_processor (
    input  wire logic                         i_mclk,
    input  wire logic                         i_reset_n,
    fps_if.processor                          link,
    output logic      [fps_pkg::KEY_W-1:0]    o_key_code,
    output logic                              o_key_strobe,
    output logic                              o_wake,
    output logic      [fps_pkg::JMP_N-1:0]    o_lockouts,
    output logic                              o_jumpers_ready,
    input  wire logic [fps_pkg::PORT_W-1:0]   i_display_data,
    input  wire logic [fps_pkg::PORT_W-1:0]   i_modem_control,
    input  wire logic [fps_pkg::PORT_W-1:0]   i_display_control,
    output logic      [fps_pkg::PORT_W-1:0]   o_display_data_port,
    output logic      [fps_pkg::PORT_W-1:0]   o_modem_control_port,
    output logic      [fps_pkg::PORT_W-1:0]   o_display_control_port
);
    logic                           rs_q, rs_d;     // restart level, see RQ4
    logic [fps_pkg::KEY_W-1:0]      kc_q, kc_d;     // last key
    logic                           ks_q, ks_d;     // key strobe
    logic                           wk_q, wk_d;     // wake copy
    logic [fps_pkg::JMP_N-1:0]      lk_q, lk_d;     // lockout image
    logic [fps_pkg::JMP_IDX_W-1:0]  jn_q, jn_d;     // bits received
    logic                           asked_q, asked_d; // request issued
    logic                           jr_q, jr_d;     // jumper read done
    logic                           req_q, req_d;   // request pulse
    logic [fps_pkg::PORT_W-1:0]     pa_q, pb_q, pc_q; // see RQ11

    // key read and restart toggle; only after key_valid, see RQ4
    always_comb begin
        rs_d = rs_q;
        kc_d = kc_q;
        ks_d = 1'b0;
        wk_d = link.wake_irq;
        if (link.key_valid && !ks_q && link.supply_rst_n) begin
            kc_d = link.key_code;
            ks_d = 1'b1;
            rs_d = ~rs_q;                        // see RQ4
        end
    end

    // single jumper read after power-up, see RQ8 and RQ9
    always_comb begin
        lk_d    = lk_q;
        jn_d    = jn_q;
        asked_d = asked_q;
        jr_d    = jr_q;
        req_d   = 1'b0;
        if (!link.supply_rst_n) begin
            asked_d = 1'b0;
            jr_d    = 1'b0;
            jn_d    = '0;
        end else if (!asked_q) begin
            req_d   = 1'b1;                      // see RQ8
            asked_d = 1'b1;
        end else if (link.jmp_sval && !jr_q) begin
            lk_d = {link.jmp_sdat, lk_q[fps_pkg::JMP_N-1:1]}; // see RQ9
            jn_d = jn_q + 1'b1;
            jr_d = (jn_q == fps_pkg::JMP_IDX_W'(fps_pkg::JMP_N - 1));
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rs_q <= 1'b0;
            kc_q <= '0;
            ks_q <= 1'b0;
            wk_q <= 1'b0;
            lk_q <= fps_pkg::JMP_RST;
            jn_q <= '0;
            asked_q <= 1'b0;
            jr_q <= 1'b0;
            req_q <= 1'b0;
            pa_q <= '0;
            pb_q <= '0;
            pc_q <= '0;
        end else begin
            rs_q <= rs_d;
            kc_q <= kc_d;
            ks_q <= ks_d;
            wk_q <= wk_d;
            lk_q <= lk_d;
            jn_q <= jn_d;
            asked_q <= asked_d;
            jr_q <= jr_d;
            req_q <= req_d;
            pa_q <= i_modem_control;             // see RQ11
            pb_q <= i_display_data;
            pc_q <= i_display_control;
        end
    end

    // core clock taken as i_mclk; crystal itself is off chip, see RQ12
    assign link.restart   = rs_q;
    assign link.jmp_req   = req_q;
    assign o_key_code     = kc_q;
    assign o_key_strobe   = ks_q;
    assign o_wake         = wk_q;
    assign o_lockouts     = lk_q;
    assign o_jumpers_ready = jr_q;
    assign o_display_data_port    = pb_q;
    assign o_modem_control_port   = pa_q;
    assign o_display_control_port = pc_q;
endmodule : fps_processor

// >>> tb/fps_props.sv
// checker for the panel link: watches only the fps_if signals
// assumes one clock and an active-low async reset shared by both ends
`timescale 1ns/1ns
module fps_props (
    input wire logic                      i_mclk,
    input wire logic                      i_reset_n,
    input wire logic                      key_valid,
    input wire logic [fps_pkg::KEY_W-1:0] key_code,
    input wire logic                      restart,
    input wire logic                      wake_irq,
    input wire logic                      supply_rst_n,
    input wire logic                      jmp_req,
    input wire logic                      jmp_sdat,
    input wire logic                      jmp_sval
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    logic [fps_pkg::PULSE_W-1:0] hi_cnt_d; // cycles the wake pulse stood
    logic [fps_pkg::PULSE_W-1:0] hi_cnt_q;
    // a counter, since the pulse is far too long to unroll
    always_comb begin
        hi_cnt_d = wake_irq ? hi_cnt_q + 1'b1 : '0;
    end
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hi_cnt_q <= '0;
        end else begin
            hi_cnt_q <= hi_cnt_d;
        end
    end
    property p_code_held;
        key_valid && $past(key_valid) |-> $stable(key_code);
    endproperty
    a_code_held: assert property (p_code_held)
        else $error("key code moved while held");
    property p_restart_resumes;
        $changed(restart) && key_valid |-> ##1 !key_valid;
    endproperty
    a_restart_resumes: assert property (p_restart_resumes)
        else $error("scan did not resume after restart");
    property p_proc_restarts;
        $rose(key_valid) |-> ##[1:2] $changed(restart);
    endproperty
    a_proc_restarts: assert property (p_proc_restarts)
        else $error("processor did not toggle restart");
    property p_fall_needs_restart;
        $fell(key_valid) |-> ($past(restart, 1) != $past(restart, 2))
            || ($past(restart, 2) != $past(restart, 3));
    endproperty
    a_fall_needs_restart: assert property (p_fall_needs_restart)
        else $error("key released without restart");
    property p_pulse_not_short;
        $fell(wake_irq) |-> hi_cnt_q == fps_pkg::PULSE_W'(fps_pkg::PULSE_CYC);
    endproperty
    a_pulse_not_short: assert property (p_pulse_not_short)
        else $error("wake pulse length wrong");
    property p_pulse_not_long;
        wake_irq |-> hi_cnt_q < fps_pkg::PULSE_W'(fps_pkg::PULSE_CYC);
    endproperty
    a_pulse_not_long: assert property (p_pulse_not_long)
        else $error("wake pulse too long");
    property p_req_after_supply;
        $rose(supply_rst_n) |-> ##[1:2] jmp_req;
    endproperty
    a_req_after_supply: assert property (p_req_after_supply)
        else $error("no jumper read after supply good");
    property p_ten_strobes;
        jmp_req && supply_rst_n |->
            ##2 jmp_sval [*8] ##1 jmp_sval [*2] ##1 !jmp_sval;
    endproperty
    a_ten_strobes: assert property (p_ten_strobes)
        else $error("jumper stream not ten strobes");
    property p_no_req_in_reset;
        !supply_rst_n |-> !jmp_req;
    endproperty
    a_no_req_in_reset: assert property (p_no_req_in_reset)
        else $error("request while processor held");
endmodule : fps_props

// >>> tb/front_panel_input_scanner_bench.sv
// bench: scanner and processor joined by fps_if, user sides driven here
// assumes the 20 ms wake pulse is never waited out, only its start
`timescale 1ns/1ns
module front_panel_input_scanner_bench;
    logic       mclk = 1'b0;    // 250 MHz
    logic       reset_n = 1'b0; // active low
    logic       push_to_talk_input = 1'b0, morse = 1'b0, sup_ok = 1'b0;
    logic [1:0] clarifier_control = 2'h0;
    logic [3:0] rows = 4'h0;
    logic [7:0] cols = 8'h00, pin = 8'h00;
    logic [9:0] jmp = 10'h259, lock, ser = 10'h000;
    logic [1:0] srow;
    logic [2:0] scol;
    logic [4:0] kcode, prev, nxt;
    logic       kstb, wake, jrdy;
    logic [7:0] po0, po1, po2;
    int         num_errors = 0, checks = 0, nbits = 0;
    fps_if i_fps_if();
    fps_scanner i_fps_scanner (.i_mclk(mclk), .i_reset_n(reset_n),
        .link(i_fps_if), .i_key_rows(rows), .i_key_cols(cols),
        .i_push_to_talk_input(push_to_talk_input), .i_morse_key_input(morse),
        .i_clarifier_control(clarifier_control), .i_supply_ok(sup_ok),
        .i_jumper_fitted(jmp), .o_scan_row(srow), .o_scan_col(scol));
    fps_processor i_fps_processor (.i_mclk(mclk), .i_reset_n(reset_n),
        .link(i_fps_if), .o_key_code(kcode), .o_key_strobe(kstb),
        .o_wake(wake), .o_lockouts(lock), .o_jumpers_ready(jrdy),
        .i_display_data(pin), .i_modem_control(~pin),
        .i_display_control(pin ^ 8'h0f), .o_display_data_port(po0),
        .o_modem_control_port(po1), .o_display_control_port(po2));
    fps_props i_fps_props (.i_mclk(mclk), .i_reset_n(reset_n),
        .key_valid(i_fps_if.key_valid), .key_code(i_fps_if.key_code),
        .restart(i_fps_if.restart), .wake_irq(i_fps_if.wake_irq),
        .supply_rst_n(i_fps_if.supply_rst_n), .jmp_req(i_fps_if.jmp_req),
        .jmp_sdat(i_fps_if.jmp_sdat), .jmp_sval(i_fps_if.jmp_sval));
    always #2 mclk = ~mclk;
    // serial jumper bits arrive lsb first, so shift in from the top
    // sampled mid-cycle, where the strobe has settled
    always @(negedge mclk) begin
        if (i_fps_if.jmp_sval === 1'b1) begin
            ser = {i_fps_if.jmp_sdat, ser[9:1]};
            nbits++;
        end
    end
    task automatic chk(input string what, input logic [9:0] e,
                       input logic [9:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    // press one key, wait for the strobe under a bound, then release
    task automatic press(input int r, input int c);
        int k;
        rows = 4'(1 << r);
        cols = 8'(1 << c);
        for (k = 0; k < 80 && kstb !== 1'b1; k++) tick(1);
        chk("strobe", 10'h001, {9'h000, kstb});
        chk("key", 10'(r * 8 + c), {5'h00, kcode});
        rows = 4'h0;
        cols = 8'h00;
        tick(6);
    endtask : press
    task automatic complete_run;
        if (num_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run
    initial begin
        #40000;
        num_errors++;
        complete_run();
    end
    initial begin
        tick(16);
        reset_n = 1'b1;
        chk("held", 10'h000, {9'h000, i_fps_if.supply_rst_n});
        push_to_talk_input = 1'b1;
        tick(3);
        chk("wake", 10'h001, {9'h000, wake});
        morse = 1'b1;
        clarifier_control = 2'h2;
        tick(8);
        chk("wake", 10'h001, {9'h000, i_fps_if.wake_irq});
        sup_ok = 1'b1;
        tick(2);
        chk("suprst", 10'h001, {9'h000, i_fps_if.supply_rst_n});
        tick(20);
        chk("serial", 10'h259, ser);
        chk("nbits", 10'd10, 10'(nbits));
        chk("lock", 10'h259, lock);
        chk("all", 10'h001, 10'(lock[fps_pkg::JMP_ALL_LOCK]));
        chk("xcvr", 10'h000, 10'(lock[fps_pkg::JMP_XCVR_LOCK]));
        chk("ready", 10'h001, {9'h000, jrdy});
        sup_ok = 1'b0;
        tick(2);
        chk("suprst", 10'h000, {9'h000, i_fps_if.supply_rst_n});
        jmp = 10'h000;
        nbits = 0;
        sup_ok = 1'b1;
        tick(20);
        chk("lock", 10'h000, lock);
        chk("nbits", 10'd10, 10'(nbits));
        chk("serial", 10'h000, ser);
        for (int i = 0; i < 40; i++) begin
            prev = {srow, scol};
            tick(1);
            nxt = prev + 5'h01; // five bits, so the last position wraps
            chk("scan", {5'h00, nxt}, {5'h00, srow, scol});
        end
        press(0, 0);
        press(3, 7);
        press(1, 5);
        press(2, 2);
        press(2, 2);
        pin = 8'h5a;
        tick(2);
        chk("port0", 10'h05a, {2'h0, po0});
        chk("port1", 10'h0a5, {2'h0, po1});
        chk("port2", 10'h055, {2'h0, po2});
        complete_run();
    end
endmodule : front_panel_input_scanner_bench
